// >>> design/bpu_status_map.svh
// Register offsets, field positions and reset values of the biphase status block
`ifndef BPU_STATUS_MAP_SVH
`define BPU_STATUS_MAP_SVH

// Register offsets
`define BPU_OFS_DATA 12'hF40
`define BPU_OFS_STATUS 12'hF41
`define BPU_OFS_CTRL 12'hF43
`define BPU_OFS_MODE 12'hF44
`define BPU_OFS_INT_STAT 12'hF48
`define BPU_OFS_INT_MASK 12'hF49

// Status field positions
`define BPU_ST_RDA 7
`define BPU_ST_BPE 6
`define BPU_ST_OVR 5
`define BPU_ST_FRM 4
`define BPU_ST_BUS_COLLISION_FLAG 3
`define BPU_ST_TX_HOLDING_EMPTY 2
`define BPU_ST_TXE 1
`define BPU_ST_CTS 0

// Control field positions
`define BPU_CT_BIPHASE_CHECK_ENABLE 0
`define BPU_CT_MULTI 1
`define BPU_CT_LOOP 2
`define BPU_CT_FLOW 3

// Mode select field
`define BPU_PROTOCOL_MODE_SELECT_HI 7
`define BPU_PROTOCOL_MODE_SELECT_LO 5
`define BPU_PROTOCOL_MODE_SELECT_BIPHASE 3'h4

// Reset values
`define BPU_CTRL_RST 8'h00
`define BPU_MODE_RST 3'h0
`define BPU_MASK_RST 8'h00
`define BPU_TX_HOLDING_EMPTY_RST 1'h1
`define BPU_TXE_RST 1'h1
`define BPU_FLAG_RST 8'h00
`define BPU_RDATA_IDLE 8'h00

`endif

// >>> design/bpu_pkg.sv
// Shared types of the biphase status block
package bpu_pkg;
  typedef logic [7:0] bpu_byte_t;
  typedef logic [11:0] bpu_addr_t;
  typedef logic [2:0] bpu_protocol_mode_select_t;
  typedef struct packed {
    logic flow_gate_enable;
    logic loopback_enable;
    logic multi_byte_rx_enable;
    logic biphase_check_enable;
  } bpu_ctrl_t;
endpackage : bpu_pkg

// >>> design/bpu_flag_if.sv
// Carrier between the status logic and a bank of sticky flags
`timescale 1ns/10ps
interface bpu_flag_if;
  bpu_pkg::bpu_byte_t set;
  bpu_pkg::bpu_byte_t clr;
  bpu_pkg::bpu_byte_t q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface : bpu_flag_if

// >>> design/bpu_sticky.sv
// Bank of eight sticky flags, set beats clear
`timescale 1ns/10ps
`include "bpu_status_map.svh"
module bpu_sticky (
  input wire logic clk,
  input wire logic rst,
  bpu_flag_if.owner flags
);

  bpu_pkg::bpu_byte_t flag_q;
  bpu_pkg::bpu_byte_t flag_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next value per bit; an event in the clearing cycle is kept
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      assign flag_d[i] = flags.set[i] | (flag_q[i] & ~flags.clr[i]);
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_q <= `BPU_FLAG_RST;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  assign flags.q = flag_q;

endmodule : bpu_sticky

// >>> design/bpu_status.sv
// Status flags, control and register port of the serial port in biphase mode
`timescale 1ns/10ps
`include "bpu_status_map.svh"

// Functional notes
// - A byte placed in the receive data register raises rx_byte_available; reading it drops it.
// - A half-bit phase error sets the biphase error flag only when checking is on; data read clears.
// - A byte arriving before the previous one was read sets overrun; a data read clears it.
// - A missing stop bit sets the framing flag only with multi-byte reception off; read clears.
// - A detected bus collision sets the collision flag; a receive data read clears it.
// - Holding-empty stays high while a byte can be taken, drops on a write; no write while low.
// - The shifter-empty flag is 1 once the character is fully sent and 0 while shifting.
// - Bit 0 returns the live clear-to-send level on every read and has no reset value.
// - With loopback on, the receive-available level stands in for the clear-to-send input.
// - Clear-to-send gates transmission only while the flow gate enable is 1.
// - This status layout and its control register appear only with mode select at 3'b100.
module bpu_status (
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire bpu_pkg::bpu_addr_t reg_addr,
  input wire bpu_pkg::bpu_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output bpu_pkg::bpu_byte_t reg_rdata,
  // Receive datapath
  input wire logic rx_byte_valid,
  input wire bpu_pkg::bpu_byte_t rx_byte_data,
  input wire logic rx_phase_error,
  input wire logic rx_stop_missing,
  input wire logic rx_collision,
  // Transmit datapath
  input wire logic tx_take,
  input wire logic tx_shift_busy,
  output bpu_pkg::bpu_byte_t tx_byte_data,
  output logic tx_byte_pending,
  output logic tx_permit,
  output logic loopback_active,
  // Line and system
  input wire logic cts_n,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bpu_pkg::bpu_ctrl_t ctrl_q;
  bpu_pkg::bpu_protocol_mode_select_t protocol_mode_select_q;
  bpu_pkg::bpu_byte_t int_mask_q;
  bpu_pkg::bpu_byte_t rx_data_q;
  bpu_pkg::bpu_byte_t tx_data_q;
  bpu_pkg::bpu_byte_t reg_rdata_q;
  bpu_pkg::bpu_byte_t read_mux;
  bpu_pkg::bpu_byte_t status_now;
  bpu_pkg::bpu_byte_t status_prev_q;
  bpu_pkg::bpu_byte_t err_set;
  bpu_pkg::bpu_byte_t int_set;
  bpu_pkg::bpu_byte_t int_clr;
  logic rda_q;
  logic tx_holding_empty_q;
  logic txe_q;
  logic tx_permit_q;
  logic loop_q;
  logic irq_q;
  logic mode_ok;
  logic sel_data;
  logic sel_status;
  logic sel_ctrl;
  logic sel_mode;
  logic sel_int_stat;
  logic sel_int_mask;
  logic data_rd;
  logic data_wr;
  logic cts_level;

  bpu_flag_if err_if ();
  bpu_flag_if int_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign sel_data = (reg_addr == `BPU_OFS_DATA);
  assign sel_status = (reg_addr == `BPU_OFS_STATUS);
  assign sel_ctrl = (reg_addr == `BPU_OFS_CTRL);
  assign sel_mode = (reg_addr == `BPU_OFS_MODE);
  assign sel_int_stat = (reg_addr == `BPU_OFS_INT_STAT);
  assign sel_int_mask = (reg_addr == `BPU_OFS_INT_MASK);

  assign mode_ok = (protocol_mode_select_q == `BPU_PROTOCOL_MODE_SELECT_BIPHASE);
  assign data_rd = reg_rd & sel_data;
  // A write while the holding register is full would destroy a byte
  assign data_wr = reg_wr & sel_data & tx_holding_empty_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode select and control
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      protocol_mode_select_q <= `BPU_MODE_RST;
    end
    else if (reg_wr && sel_mode)
    begin
      protocol_mode_select_q <= reg_wdata[`BPU_PROTOCOL_MODE_SELECT_HI:`BPU_PROTOCOL_MODE_SELECT_LO];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= bpu_pkg::bpu_ctrl_t'(`BPU_CTRL_RST);
    end
    else if (reg_wr && sel_ctrl && mode_ok)
    begin
      ctrl_q.biphase_check_enable <= reg_wdata[`BPU_CT_BIPHASE_CHECK_ENABLE];
      ctrl_q.multi_byte_rx_enable <= reg_wdata[`BPU_CT_MULTI];
      ctrl_q.loopback_enable <= reg_wdata[`BPU_CT_LOOP];
      ctrl_q.flow_gate_enable <= reg_wdata[`BPU_CT_FLOW];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive data register and available flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_data_q <= `BPU_FLAG_RST;
    end
    else if (rx_byte_valid)
    begin
      // Newest byte wins; the lost one is reported as overrun
      rx_data_q <= rx_byte_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rda_q <= 1'b0;
    end
    else if (rx_byte_valid)
    begin
      rda_q <= 1'b1;
    end
    else if (data_rd)
    begin
      rda_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive error flags
  always_comb
  begin
    err_set = 8'h00;
    err_set[`BPU_ST_BPE] = rx_phase_error & ctrl_q.biphase_check_enable;
    // A read in the same cycle counts as having taken the old byte
    err_set[`BPU_ST_OVR] = rx_byte_valid & rda_q & ~data_rd;
    err_set[`BPU_ST_FRM] = rx_stop_missing & ~ctrl_q.multi_byte_rx_enable;
    err_set[`BPU_ST_BUS_COLLISION_FLAG] = rx_collision;
  end

  assign err_if.set = err_set;
  assign err_if.clr = {8{data_rd}};

  bpu_sticky u_err (
    .clk (clk),
    .rst (rst),
    .flags (err_if.owner)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding register and flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_data_q <= `BPU_FLAG_RST;
    end
    else if (data_wr)
    begin
      tx_data_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_holding_empty_q <= `BPU_TX_HOLDING_EMPTY_RST;
    end
    else if (data_wr)
    begin
      // Write beats take: the new byte must not be marked as sent
      tx_holding_empty_q <= 1'b0;
    end
    else if (tx_take)
    begin
      tx_holding_empty_q <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txe_q <= `BPU_TXE_RST;
    end
    else
    begin
      txe_q <= ~tx_shift_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear-to-send and flow gating
  // Active low pin: a 1 level holds the transmitter
  assign cts_level = ctrl_q.loopback_enable ? rda_q : cts_n;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_permit_q <= 1'b1;
    end
    else
    begin
      tx_permit_q <= ~ctrl_q.flow_gate_enable | ~cts_level;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loop_q <= 1'b0;
    end
    else
    begin
      loop_q <= ctrl_q.loopback_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word
  always_comb
  begin
    status_now = err_if.q;
    status_now[`BPU_ST_RDA] = rda_q;
    status_now[`BPU_ST_TX_HOLDING_EMPTY] = tx_holding_empty_q;
    status_now[`BPU_ST_TXE] = txe_q;
    status_now[`BPU_ST_CTS] = cts_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: rising edge of any flag above the clear-to-send bit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_prev_q <= {`BPU_FLAG_RST | 8'h06};
    end
    else
    begin
      status_prev_q <= status_now;
    end
  end

  always_comb
  begin
    int_set = status_now & ~status_prev_q;
    int_set[`BPU_ST_CTS] = 1'b0;
  end

  assign int_clr = (reg_wr && sel_int_stat) ? reg_wdata : 8'h00;
  assign int_if.set = int_set;
  assign int_if.clr = int_clr;

  bpu_sticky u_int (
    .clk (clk),
    .rst (rst),
    .flags (int_if.owner)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      int_mask_q <= `BPU_MASK_RST;
    end
    else if (reg_wr && sel_int_mask)
    begin
      int_mask_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(int_if.q & int_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; status writes fall through with no decode
  always_comb
  begin
    read_mux = `BPU_RDATA_IDLE;
    if (sel_data)
    begin
      read_mux = rx_data_q;
    end
    else if (sel_status && mode_ok)
    begin
      read_mux = status_now;
    end
    else if (sel_ctrl && mode_ok)
    begin
      read_mux = {4'h0, ctrl_q};
    end
    else if (sel_mode)
    begin
      // Mode status field belongs to other protocol layouts
      read_mux = {protocol_mode_select_q, 5'h00};
    end
    else if (sel_int_stat)
    begin
      read_mux = int_if.q;
    end
    else if (sel_int_mask)
    begin
      read_mux = int_mask_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata_q <= `BPU_RDATA_IDLE;
    end
    else if (reg_rd)
    begin
      reg_rdata_q <= read_mux;
    end
    else
    begin
      reg_rdata_q <= `BPU_RDATA_IDLE;
    end
  end

  // no write to the status offset reaches the status flags

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = reg_rdata_q;
  assign tx_byte_data = tx_data_q;
  assign tx_byte_pending = ~tx_holding_empty_q;
  assign tx_permit = tx_permit_q;
  assign loopback_active = loop_q;
  assign irq = irq_q;

endmodule : bpu_status

// >>> testbench/bpu_line_model.sv
// Line-side stand-in: receiver and transmitter datapaths and the send-gate pin
`timescale 1ns/10ps
module bpu_line_model (
  input wire logic clk,
  input wire logic tx_permit,
  output logic rx_byte_valid,
  output bpu_pkg::bpu_byte_t rx_byte_data,
  output logic rx_phase_error,
  output logic rx_stop_missing,
  output logic rx_collision,
  output logic tx_take,
  output logic tx_shift_busy,
  output logic cts_n
);
  initial
  begin
    {rx_byte_valid, rx_phase_error, rx_stop_missing, rx_collision} = 4'h0;
    {tx_take, tx_shift_busy, cts_n} = 3'h1;
    rx_byte_data = 8'h00;
  end
  ////////////////////////////////////////
  // Byte held n cycles with error pulses {phase, stop, collision}
  task automatic rx(input bpu_pkg::bpu_byte_t d, input logic [2:0] e, input int n);
    rx_byte_valid <= 1'b1;
    rx_byte_data <= d;
    {rx_phase_error, rx_stop_missing, rx_collision} <= e;
    repeat (n) @(posedge clk);
    rx_byte_valid <= 1'b0;
    // Released data must not keep showing the byte
    rx_byte_data <= ~d;
    {rx_phase_error, rx_stop_missing, rx_collision} <= 3'h0;
  endtask : rx
  task automatic tx_start();
    while (tx_permit !== 1'b1) @(posedge clk);
    tx_take <= 1'b1;
    tx_shift_busy <= 1'b1;
    @(posedge clk);
    tx_take <= 1'b0;
  endtask : tx_start
  task automatic tx_end();
    tx_shift_busy <= 1'b0;
    @(posedge clk);
  endtask : tx_end
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask : set_cts
endmodule : bpu_line_model

// >>> testbench/bpu_status_checker.sv
// Port assertions of the biphase status block
`timescale 1ns/10ps
`include "bpu_status_map.svh"
module bpu_status_checker (
  input wire logic clk,
  input wire logic rst,
  input wire bpu_pkg::bpu_addr_t reg_addr,
  input wire bpu_pkg::bpu_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire bpu_pkg::bpu_byte_t reg_rdata,
  input wire logic rx_byte_valid,
  input wire logic rx_phase_error,
  input wire logic rx_stop_missing,
  input wire logic rx_collision,
  input wire logic tx_take,
  input wire logic tx_shift_busy,
  input wire bpu_pkg::bpu_byte_t tx_byte_data,
  input wire logic tx_byte_pending,
  input wire logic tx_permit,
  input wire logic loopback_active,
  input wire logic cts_n
);
  logic rd_st;
  logic rd_dt;
  logic wr_dt;
  logic evt;
  assign rd_st = reg_rd && reg_addr == `BPU_OFS_STATUS;
  assign rd_dt = reg_rd && reg_addr == `BPU_OFS_DATA;
  assign wr_dt = reg_wr && reg_addr == `BPU_OFS_DATA;
  assign evt = rx_byte_valid | rx_phase_error | rx_stop_missing | rx_collision;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Outside biphase mode status reads zero, so the zero escape is allowed
  sequence s_two_bytes;
    rx_byte_valid ##1 rx_byte_valid && !rd_dt;
  endsequence
  sequence s_clear_look;
    rd_dt && !evt ##1 rd_st && !evt;
  endsequence
  a_hold_load:
    assert property (wr_dt && !tx_byte_pending |=> tx_byte_pending
      && tx_byte_data == $past(reg_wdata)) else $error("holding byte not loaded");
  a_take_empties:
    assert property (tx_take && !wr_dt |=> !tx_byte_pending) else $error("take kept byte");
  a_shift_busy:
    assert property (tx_shift_busy [*2] ##0 rd_st |=> !reg_rdata[1])
      else $error("empty while shifting");
  // Loopback output lags its control bit by one cycle, so look one cycle on
  a_cts_level:
    assert property (rd_st |=> loopback_active || reg_rdata[0] == $past(cts_n)
      || reg_rdata == 8'h00) else $error("bit0 not pin");
  a_loop_cts:
    assert property (rd_st |=> !loopback_active || reg_rdata[0] == reg_rdata[7])
      else $error("loopback bit0 wrong");
  a_rx_seen:
    assert property (rx_byte_valid ##1 rd_st |=> reg_rdata[7] || reg_rdata == 8'h00)
      else $error("byte not flagged");
  a_overrun_seen:
    assert property (s_two_bytes ##1 rd_st |=> reg_rdata[5] || reg_rdata == 8'h00)
      else $error("overrun missed");
  a_read_clears:
    assert property (s_clear_look |=> reg_rdata[7:3] == 5'h00) else $error("flags kept");
  a_gate_level:
    assert property (!tx_permit && !loopback_active && $stable(loopback_active)
      |-> $past(cts_n)) else $error("blocked with pin clear");
endmodule : bpu_status_checker

bind bpu_status bpu_status_checker i_bpu_status_checker (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_byte_valid(rx_byte_valid), .rx_phase_error(rx_phase_error),
  .rx_stop_missing(rx_stop_missing), .rx_collision(rx_collision), .tx_take(tx_take),
  .tx_shift_busy(tx_shift_busy), .tx_byte_data(tx_byte_data),
  .tx_byte_pending(tx_byte_pending), .tx_permit(tx_permit),
  .loopback_active(loopback_active), .cts_n(cts_n));

// >>> testbench/testbench.sv
// Self-checking testbench of the biphase status block
`timescale 1ns/10ps
`include "bpu_status_map.svh"
module testbench;
  localparam bpu_pkg::bpu_addr_t a_dt = `BPU_OFS_DATA;
  localparam bpu_pkg::bpu_addr_t a_st = `BPU_OFS_STATUS;
  localparam bpu_pkg::bpu_addr_t a_ct = `BPU_OFS_CTRL;
  localparam bpu_pkg::bpu_addr_t a_is = `BPU_OFS_INT_STAT;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  bpu_pkg::bpu_addr_t reg_addr = 12'h000;
  bpu_pkg::bpu_byte_t reg_wdata = 8'h00;
  bpu_pkg::bpu_byte_t reg_rdata, tx_byte_data, rx_byte_data;
  logic rx_byte_valid, rx_phase_error, rx_stop_missing, rx_collision, tx_take;
  logic tx_shift_busy, cts_n, tx_byte_pending, tx_permit, loopback_active, irq;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  bpu_status i_bpu_status (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_byte_valid(rx_byte_valid), .rx_byte_data(rx_byte_data),
    .rx_phase_error(rx_phase_error), .rx_stop_missing(rx_stop_missing),
    .rx_collision(rx_collision), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
    .tx_byte_data(tx_byte_data), .tx_byte_pending(tx_byte_pending),
    .tx_permit(tx_permit), .loopback_active(loopback_active), .cts_n(cts_n), .irq(irq));
  bpu_line_model i_line (.clk(clk), .tx_permit(tx_permit), .rx_byte_valid(rx_byte_valid),
    .rx_byte_data(rx_byte_data), .rx_phase_error(rx_phase_error),
    .rx_stop_missing(rx_stop_missing), .rx_collision(rx_collision), .tx_take(tx_take),
    .tx_shift_busy(tx_shift_busy), .cts_n(cts_n));
  ////////////////////////////////////////
  task automatic chk(input bpu_pkg::bpu_byte_t got, input bpu_pkg::bpu_byte_t exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Every bus task ends just after an edge, so strobes never collide
  task automatic wr(input bpu_pkg::bpu_addr_t a, input bpu_pkg::bpu_byte_t d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input bpu_pkg::bpu_addr_t a, input bpu_pkg::bpu_byte_t exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Signal is read after the wait; an input argument would freeze it at the call
  task automatic wait_chk(input int n, input logic pick_irq, input logic exp_bit);
    repeat (n) @(posedge clk);
    #1 chk({7'h00, pick_irq ? irq : tx_permit}, {7'h00, exp_bit});
  endtask : wait_chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  task automatic t_mode();
    rd(a_st, 8'h00);
    wr(a_ct, 8'h0F);
    wr(`BPU_OFS_MODE, 8'h80);
    rd(`BPU_OFS_MODE, 8'h80);
    rd(a_ct, 8'h00);
    rd(a_st, 8'h07);
    wr(a_st, 8'hFF);
    rd(a_st, 8'h07);
    rd(12'hF4F, 8'h00);
    $display("test mode done");
  endtask : t_mode
  task automatic t_rx();
    i_line.rx(8'hA5, 3'h0, 1);
    rd(a_st, 8'h87);
    i_line.rx(8'h3C, 3'h7, 2);
    rd(a_st, 8'hBF);
    rd(a_dt, 8'h3C);
    rd(a_st, 8'h07);
    wr(a_ct, 8'h03);
    rd(a_ct, 8'h03);
    i_line.rx(8'h11, 3'h6, 1);
    rd(a_st, 8'hC7);
    rd(a_dt, 8'h11);
    rd(a_st, 8'h07);
    $display("test rx done");
  endtask : t_rx
  task automatic t_tx();
    wr(a_dt, 8'h5A);
    chk(tx_byte_data, 8'h5A);
    chk({7'h00, tx_byte_pending}, 8'h01);
    rd(a_st, 8'h03);
    wr(a_dt, 8'hC3);
    chk(tx_byte_data, 8'h5A);
    i_line.tx_start();
    rd(a_st, 8'h05);
    i_line.tx_end();
    rd(a_st, 8'h07);
    $display("test tx done");
  endtask : t_tx
  task automatic t_cts();
    i_line.set_cts(1'b0);
    rd(a_st, 8'h06);
    wr(a_ct, 8'h08);
    wait_chk(2, 1'b0, 1'b1);
    i_line.set_cts(1'b1);
    wait_chk(2, 1'b0, 1'b0);
    wr(a_ct, 8'h00);
    wait_chk(2, 1'b0, 1'b1);
    wr(a_ct, 8'h0C);
    rd(a_st, 8'h06);
    chk({7'h00, loopback_active}, 8'h01);
    i_line.rx(8'h77, 3'h0, 1);
    rd(a_st, 8'h87);
    wait_chk(0, 1'b0, 1'b0);
    rd(a_dt, 8'h77);
    wr(a_ct, 8'h00);
    $display("test cts done");
  endtask : t_cts
  task automatic t_irq();
    wr(a_is, 8'hFF);
    wr(`BPU_OFS_INT_MASK, 8'h80);
    i_line.rx(8'h01, 3'h0, 1);
    wait_chk(2, 1'b1, 1'b1);
    rd(a_is, 8'h80);
    rd(a_dt, 8'h01);
    wr(a_is, 8'h80);
    wait_chk(1, 1'b1, 1'b0);
    wr(`BPU_OFS_INT_MASK, 8'h00);
    i_line.rx(8'h02, 3'h1, 1);
    wait_chk(3, 1'b1, 1'b0);
    rd(a_is, 8'h88);
    $display("test irq done");
  endtask : t_irq
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      test_done();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_mode();
    t_rx();
    t_tx();
    t_cts();
    t_irq();
    test_done();
  end
endmodule : testbench
